// File: pkg/usi_pkg.sv
// Purpose: constants and types shared by the serial clock source select block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   register offsets below are byte addresses
// Summary of operation
// [R1] source 00 gives no clock unless the strobe bit is written one; source 01 clocks on timer match
// [R2] upper select one clocks the shift register on the chosen pin edge, the counter on both while the stored strobe bit is zero
// [R3] with the pin clock, data out changes on the edge opposite to the data sampling edge
// [R4] with strobe or timer clocking, data out follows the shift register at once
// [R5] in strobe mode each write of one to the strobe bit shifts once and counts once
// [R6] a strobe changes data out in the write cycle and shifts in the data sampled before it
// [R7] the strobe bit and the toggle bit always read back as zero
// [R8] with the pin clock the stored strobe bit picks pin edges or toggle writes for the counter
// [R9] each write of one to the toggle bit inverts the clock port value, shown only when driven
// [R10] pin clock with strobe bit set: each toggle write advances the counter by one
// [R11] the serial clock pin is synchronised and edge detected before it clocks anything
package usi_pkg;

    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_PORT  = 8'h04;
    localparam logic [7:0] ADDR_DATA  = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0C;

    localparam int CTRL_TOGGLE_BIT = 0;
    localparam int CTRL_STROBE_BIT = 1;
    localparam int CTRL_SEL_LSB    = 2;
    localparam int CTRL_SEL_MSB    = 3;
    localparam int PORT_VALUE_BIT  = 0;
    localparam int PORT_DIR_BIT    = 1;

    localparam int DATA_W  = 8;
    localparam int COUNT_W = 4;

    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [7:0]  SHIFT_RST  = 8'h00;
    localparam logic [3:0]  COUNT_RST  = 4'h0;

    typedef enum logic [1:0] {
        SRC_SOFT    = 2'b00,
        SRC_TIMER   = 2'b01,
        SRC_EXT_POS = 2'b10,
        SRC_EXT_NEG = 2'b11
    } usi_src_type;

    typedef struct packed {
        logic sck;
        logic din;
    } usi_pins_type;

    typedef struct packed {
        usi_src_type src;
        logic        strobe_sel;
        logic        port_value;
        logic        port_dir;
    } usi_ctrl_type;

    localparam usi_ctrl_type CTRL_RST = '{src: SRC_SOFT, strobe_sel: 1'b0,
                                          port_value: 1'b0, port_dir: 1'b0};

endpackage

// File: verif/usi_clock_source_select_bench.sv
// Purpose: self-checking bench for the clock source select block
// Assumes: apb slave of any latency, remote master on the pins
// Notes:   integer model tracks shift, count and port bits
`timescale 1ns/1ps
`default_nettype none
module usi_clock_source_select_bench;
    import usi_pkg::*;
    logic        pclk, presetn, link_clk, psel, penable, pwrite, timer_match;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, e, sck_out, sck_oe, sck_rem, din, data_out;
    int          failures, n_tests, shf, prv, cnt, pv, pd, b, n;
    // pin level: design wins while it drives
    wire logic   sck_pin = sck_oe ? sck_out : sck_rem;

    usi_clock_source_select u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .link_clk(link_clk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_match(timer_match), .serial_clock_pin_in(sck_pin),
        .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
        .serial_data_input(din), .data_out(data_out));
    usi_remote u_rem (.link_clk(link_clk), .sck(sck_rem), .din(din));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits for pready with no assumed latency
    // only the watchdog ends a wait that never sees pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, 32'(exp));
    endtask
    task automatic sh(input int v);
        prv = shf;
        shf = ((shf << 1) | v) & 255;
    endtask
    task automatic dout(input int v);
        chk({31'h0, data_out}, 32'((v >> 7) & 1));
    endtask

    initial begin
        #200000;
        failures++;
        close_out();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; timer_match = 1'b0;
        failures = 0; n_tests = 0; shf = 0; cnt = 0; pv = 0; pd = 0;
        void'($urandom(45));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL, 0);
        rd(ADDR_DATA, 0);
        rd(ADDR_COUNT, 0);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        // software strobes
        for (int i = 0; i < 6; i++) begin
            b = $urandom % 2;
            u_rem.set_din(b[0]);
            repeat (8) @(posedge pclk);
            wr(ADDR_CTRL, 32'h0000_0002);
            sh(b); cnt++;
            #1 dout(shf);
        end
        wr(ADDR_CTRL, 32'h0000_0000);
        timer_match <= 1'b1;
        @(posedge pclk) timer_match <= 1'b0;
        rd(ADDR_DATA, shf);
        rd(ADDR_COUNT, cnt % 16);
        // timer compare match, strobe bit has no effect
        wr(ADDR_CTRL, 32'h0000_0006);
        for (int i = 0; i < 5; i++) begin
            b = $urandom % 2;
            u_rem.set_din(b[0]);
            repeat (8) @(posedge pclk);
            timer_match <= 1'b1;
            @(posedge pclk) timer_match <= 1'b0;
            sh(b); cnt++;
            #1 dout(shf);
        end
        rd(ADDR_COUNT, cnt % 16);
        // external clock, both edges
        for (int m = 8; m <= 12; m += 4) begin
            wr(ADDR_CTRL, 32'(m));
            b = $urandom % 256;
            // bit counts of 1 to 8; only a count of 8 lets a dead counter hide behind the wrap
            n = 1 + $urandom % 8;
            u_rem.send(b[7:0], n);
            repeat (10) @(posedge pclk);
            for (int i = 7; i >= 8 - n; i--) sh((b >> i) & 1);
            cnt += 2 * n;
            dout(m == 8 ? shf : prv);
            rd(ADDR_DATA, shf);
            rd(ADDR_COUNT, cnt % 16);
        end
        // external clock, counter on toggle writes once the select bit is stored
        wr(ADDR_CTRL, 32'h0000_000B);
        pv ^= 1;
        rd(ADDR_COUNT, cnt % 16);
        wr(ADDR_CTRL, 32'h0000_000B);
        cnt++; pv ^= 1;
        rd(ADDR_CTRL, 8);
        rd(ADDR_COUNT, cnt % 16);
        b = $urandom % 256;
        u_rem.send(b[7:0], 8);
        repeat (10) @(posedge pclk);
        for (int i = 7; i >= 0; i--) sh((b >> i) & 1);
        rd(ADDR_COUNT, cnt % 16);
        rd(ADDR_DATA, shf);
        rd(ADDR_PORT, pv);
        // drive the clock pin as master
        wr(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_PORT, 32'h0000_0002);
        pv = 0; pd = 1;
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, 32'h0000_0001);
            pv ^= 1;
            repeat (2) @(posedge pclk);
            chk({30'h0, sck_oe, sck_out}, 32'(2 * pd + pv));
        end
        rd(ADDR_PORT, 2 * pd + pv);
        rd(ADDR_DATA, shf);
        close_out();
    end
endmodule // usi_clock_source_select_bench
`default_nettype wire

// File: verif/usi_remote.sv
// Purpose: remote serial master driving the clock and data pins
// Assumes: link clock comes from the bench
// Notes:   clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module usi_remote (
    // link clock
    input  wire logic link_clk,
    // pins
    output logic      sck,
    output logic      din
);
    initial begin
        sck = 1'b0;
        din = 1'b0;
    end
    task automatic set_din(input logic b);
        din <= b;
    endtask
    // msb first, n bits, clock low four link cycles and high three so data is settled at both edges
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i >= 8 - n; i--) begin
            @(posedge link_clk) din <= b[i];
            repeat (3) @(posedge link_clk);
            sck <= 1'b1;
            repeat (3) @(posedge link_clk);
            sck <= 1'b0;
        end
        repeat (3) @(posedge link_clk);
        // released line must not show a stale value
        din <= ~din;
    endtask
endmodule // usi_remote
`default_nettype wire

// File: verilog/usi_clock_source_select.sv
// Purpose: clock source selection for the shift register and bit counter
// Assumes: apb slave on pclk, pins sampled in the link_clk domain first
// Notes:   one wait state on every apb access
`timescale 1ns/1ps
`default_nettype none
module usi_clock_source_select
    import usi_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int CW = COUNT_W
) (
    // system clock, reset, enable
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    // link clock that samples the pins
    input  wire logic          link_clk,
    // apb slave
    input  wire logic [7:0]    paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // timer compare match, pclk domain
    input  wire logic          timer_match,
    // serial pins
    input  wire logic          serial_clock_pin_in,
    output logic               serial_clock_pin_out,
    output logic               serial_clock_pin_oe,
    input  wire logic          serial_data_input,
    output logic               data_out
);
    usi_pins_type  pins_raw;
    usi_pins_type  pins_link;
    usi_pins_type  pins_sys;
    logic          sck_rise;
    logic          sck_fall;

    usi_ctrl_type  ctrl_reg;
    usi_ctrl_type  ctrl_next;
    logic [DW-1:0] shift_reg;
    logic [DW-1:0] shift_next;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          dout_reg;
    logic          dout_next;
    logic          pready_reg;
    logic          pready_next;
    logic [31:0]   prdata_reg;
    logic [31:0]   prdata_next;
    logic          pslverr_reg;
    logic          pslverr_next;

    logic          commit;
    logic          wr_ctrl;
    logic          wr_port;
    logic          wr_data;
    logic          wr_count;
    logic          hit;
    usi_src_type   wsrc;
    logic          strobe_evt;
    logic          toggle_evt;
    logic          toggle_cnt;
    logic          ext;
    logic          shift_en;
    logic          count_en;

    // pins cross twice: into the link domain, then into pclk
    assign pins_raw = '{sck: serial_clock_pin_in, din: serial_data_input};

    usi_sync #(.W(2)) u_link_sync (
        .clk   (link_clk),
        .rst_n (presetn),
        .en    (1'b1),
        .d     (pins_raw),
        .q     (pins_link)
    );

    usi_sync #(.W(2)) u_sys_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (ce),
        .d     (pins_link),
        .q     (pins_sys)
    );

    usi_edge u_sck_edge (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (ce),
        .level (pins_sys.sck), // R11
        .rise  (sck_rise),
        .fall  (sck_fall)
    );

    // apb decode; the write lands on the edge where pready is seen high
    always_comb begin
        commit   = psel & penable & pready_reg;
        wr_ctrl  = commit & pwrite & (paddr == ADDR_CTRL);
        wr_port  = commit & pwrite & (paddr == ADDR_PORT);
        wr_data  = commit & pwrite & (paddr == ADDR_DATA);
        wr_count = commit & pwrite & (paddr == ADDR_COUNT);
        hit      = (paddr == ADDR_CTRL) | (paddr == ADDR_PORT) |
                   (paddr == ADDR_DATA) | (paddr == ADDR_COUNT);
        wsrc     = usi_src_type'(pwdata[CTRL_SEL_MSB:CTRL_SEL_LSB]);
        ext      = ctrl_reg.src[1];
    end

    // strobes act only when the mode written in the same access selects them: 00 to shift, upper bit one to count a toggle
    always_comb begin
        strobe_evt = wr_ctrl & (wsrc == SRC_SOFT) & pwdata[CTRL_STROBE_BIT]; // R5
        toggle_evt = wr_ctrl & pwdata[CTRL_TOGGLE_BIT]; // R9
        toggle_cnt = toggle_evt & wsrc[1] & pwdata[CTRL_STROBE_BIT]; // R10
    end

    // clock source selection
    always_comb begin
        case (ctrl_reg.src)
            SRC_SOFT:    shift_en = strobe_evt; // R1
            SRC_TIMER:   shift_en = timer_match; // R1
            SRC_EXT_POS: shift_en = sck_rise; // R2
            SRC_EXT_NEG: shift_en = sck_fall; // R2
            default:     shift_en = 1'b0;
        endcase
        if (ext) begin
            // stored strobe bit now selects the counter source
            count_en = ctrl_reg.strobe_sel ? toggle_cnt : (sck_rise | sck_fall); // R8
        end else begin
            count_en = shift_en; // R1
        end
    end

    // control and port state
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next.src        = wsrc;
            ctrl_next.strobe_sel = pwdata[CTRL_STROBE_BIT]; // R8
        end
        if (wr_port) begin
            ctrl_next.port_value = pwdata[PORT_VALUE_BIT];
            ctrl_next.port_dir   = pwdata[PORT_DIR_BIT];
        end
        if (toggle_evt) begin
            ctrl_next.port_value = ~ctrl_reg.port_value; // R9
        end
    end

    // shift register, counter and output latch
    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        if (wr_data) begin
            shift_next = pwdata[DW-1:0];
        end else if (shift_en) begin
            // synced input already holds the value of the previous cycle
            shift_next = {shift_reg[DW-2:0], pins_sys.din}; // R6
        end
        if (wr_count) begin
            count_next = pwdata[CW-1:0];
        end else if (count_en) begin
            count_next = count_reg + 1'b1; // R5
        end
        case (ctrl_reg.src)
            SRC_EXT_POS: dout_next = sck_fall ? shift_reg[DW-1] : dout_reg; // R3
            SRC_EXT_NEG: dout_next = sck_rise ? shift_reg[DW-1] : dout_reg; // R3
            default:     dout_next = shift_next[DW-1]; // R4
        endcase
    end

    // apb answer
    always_comb begin
        pready_next  = psel & penable & ~pready_reg;
        prdata_next  = RDATA_ZERO;
        pslverr_next = 1'b0;
        if (pready_next) begin
            pslverr_next = ~hit;
            case (paddr)
                ADDR_CTRL: begin
                    // strobe and toggle bits never read back
                    prdata_next[CTRL_SEL_MSB:CTRL_SEL_LSB] = ctrl_reg.src; // R7
                end
                ADDR_PORT: begin
                    prdata_next[PORT_VALUE_BIT] = ctrl_reg.port_value;
                    prdata_next[PORT_DIR_BIT]   = ctrl_reg.port_dir;
                end
                ADDR_DATA:  prdata_next[DW-1:0] = shift_reg;
                ADDR_COUNT: prdata_next[CW-1:0] = count_reg;
                default:    prdata_next = RDATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= CTRL_RST;
            shift_reg   <= SHIFT_RST[DW-1:0];
            count_reg   <= COUNT_RST[CW-1:0];
            dout_reg    <= 1'b0;
            pready_reg  <= 1'b0;
            prdata_reg  <= RDATA_ZERO;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            ctrl_reg    <= ctrl_next;
            shift_reg   <= shift_next;
            count_reg   <= count_next;
            dout_reg    <= dout_next;
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
    assign data_out             = dout_reg;
    assign serial_clock_pin_out = ctrl_reg.port_value; // R9
    assign serial_clock_pin_oe  = ctrl_reg.port_dir; // R9

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IDLE_NO_CLOCK: assert property ( // R1
        (ce && ctrl_reg.src == SRC_SOFT && !wr_ctrl && !wr_count && !wr_data)
        |=> (count_reg == $past(count_reg) && shift_reg == $past(shift_reg)))
        else $error("counter or shift moved with no clock source");

    AST_TIMER_CLOCKS: assert property ( // R1
        (ce && ctrl_reg.src == SRC_TIMER && timer_match && !wr_count && !wr_data)
        |=> (count_reg == $past(count_reg) + 1'b1))
        else $error("timer match did not advance counter");

    AST_EXT_BOTH_EDGES: assert property ( // R2
        (ce && ext && !ctrl_reg.strobe_sel && (sck_rise || sck_fall) && !wr_count)
        |=> (count_reg == $past(count_reg) + 1'b1))
        else $error("pin edge did not advance counter");

    AST_EXT_POS_HOLD: assert property ( // R3
        (ce && ctrl_reg.src == SRC_EXT_POS && !sck_fall && !wr_ctrl)
        |=> (data_out == $past(data_out)))
        else $error("data out changed off the opposite edge");

    AST_TRANSPARENT: assert property ( // R4
        (!ext && $past(ce) && !$past(wr_ctrl)) |-> (data_out == shift_reg[DW-1]))
        else $error("data out not following shift register");

    AST_STROBE_SHIFT: assert property ( // R6
        (ce && strobe_evt && ctrl_reg.src == SRC_SOFT)
        |=> (shift_reg == {$past(shift_reg[DW-2:0]), $past(pins_sys.din)}
             && data_out == shift_reg[DW-1]))
        else $error("strobe shift wrong");

    AST_STROBE_COUNT: assert property ( // R5
        (ce && strobe_evt && ctrl_reg.src == SRC_SOFT)
        |=> (count_reg == $past(count_reg) + 1'b1))
        else $error("strobe did not count once");

    AST_READ_ZERO: assert property ( // R7
        (pready && paddr == ADDR_CTRL)
        |-> (prdata[CTRL_STROBE_BIT] == 1'b0 && prdata[CTRL_TOGGLE_BIT] == 1'b0))
        else $error("strobe or toggle bit read as one");

    AST_TOGGLE_PIN: assert property ( // R9
        (ce && toggle_evt && !wr_port)
        |=> (serial_clock_pin_out == !$past(serial_clock_pin_out)))
        else $error("toggle write did not invert clock port");

    AST_TOGGLE_COUNT: assert property ( // R10
        (ce && ext && ctrl_reg.strobe_sel && toggle_cnt)
        |=> (count_reg == $past(count_reg) + 1'b1))
        else $error("toggle write did not advance counter");

endmodule // usi_clock_source_select
`default_nettype wire

// File: verilog/usi_edge.sv
// Purpose: rise and fall detection on a synchronised level
// Assumes: input already synchronised to clk
// Notes:   pulses last one enabled cycle
`timescale 1ns/1ps
`default_nettype none
module usi_edge
    import usi_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    // level in, pulses out
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    logic prev_reg;
    logic prev_next;

    always_comb begin
        prev_next = en ? level : prev_reg;
        rise      = en & level & ~prev_reg;
        fall      = en & ~level & prev_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end
endmodule // usi_edge
`default_nettype wire

// File: verilog/usi_sync.sv
// Purpose: two flip-flop level synchroniser, any width
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module usi_sync
    import usi_pkg::*;
#(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = en ? d : meta_reg;
        q_next    = en ? meta_reg : q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= meta_next;
            q        <= q_next;
        end
    end
endmodule // usi_sync
`default_nettype wire
